// ---- shared/sram_port_pkg.sv ----
// shared constants and types for the burst sram control port
package sram_port_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W = 19;        // word address width
    localparam int LANES = 4;          // byte lanes a..d
    localparam int LANE_W = 9;         // eight data bits plus parity
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int BURST_BITS = 2;     // counter touches the low two bits only
    localparam int FIFO_DEPTH = 16;    // write data staging depth
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    // ****************************************
    // pipeline cycle kinds
    // ****************************************
    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_READ = 2'b01,
        CYC_WRITE = 2'b10
    } cyc_kind_t;
endpackage

// ---- rtl/sram_wdata_fifo.sv ----
// parameterised valid/ready fifo used to stage write data
`timescale 1ns/1ps
`default_nettype none
module sram_wdata_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    // storage array
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0] wr_ptr_r; // extra bit tells full from empty
    logic [PW:0] rd_ptr_r;
    logic push;
    logic pop;
    // ****************************************
    // flags
    // ****************************************
    assign in_ready = (wr_ptr_r - rd_ptr_r) != (PW+1)'(DEPTH);
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign out_data = mem[rd_ptr_r[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // write side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end
    // array itself has no reset
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r[PW-1:0]] <= in_data;
        end
    end
    // read side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sync_burst_sram_ctrl_port.sv ----
// synchronous control front end and array of the pipelined burst sram
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_ctrl_port
    import sram_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_qualifier_n,
    input wire logic chip_select_one_n,
    input wire logic chip_select_two,
    input wire logic chip_select_three_n,
    input wire logic write_strobe_n,
    input wire logic advance_or_load,
    input wire logic burst_order_strap,
    input wire logic output_drive_n,
    input wire logic [sram_port_pkg::ADDR_W-1:0] addr_in,
    input wire logic [sram_port_pkg::LANES-1:0] byte_lane_write_sel_n,
    input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
    output logic [sram_port_pkg::DATA_W-1:0] data_out,
    output logic data_out_en,
    output logic write_data_ready
);
    import sram_port_pkg::*;
    // ****************************************
    // declarations
    // ****************************************
    logic [DATA_W-1:0] mem [DEPTH];      // storage locations
    logic [ADDR_W-1:0] addr_r;           // current access address
    logic [ADDR_W-1:0] start_addr_r;     // low bits of burst start
    logic [BURST_BITS-1:0] burst_cnt_r;  // steps taken in burst
    logic order_r;                       // latched burst order
    logic order_taken_r;                 // strap caught once after reset
    cyc_kind_t stage_r;                  // kind of the pending cycle
    logic [LANES-1:0] lane_we_r;         // lanes enabled for pending write
    logic was_desel_r;                   // previous cycle was deselected
    logic [DATA_W-1:0] data_out_r;
    logic data_out_en_r;
    logic go;                            // qualified edge
    logic sel;                           // chip selected this edge
    logic [ADDR_W-1:0] next_addr;
    logic [BURST_BITS-1:0] next_cnt;
    logic [ADDR_W+LANES-1:0] wr_req;
    logic wr_req_valid;
    logic fifo_in_ready;
    logic write_data_ready_r;            // registered copy of fifo space
    logic [DATA_W+LANES+ADDR_W-1:0] fifo_in;
    logic [DATA_W+LANES+ADDR_W-1:0] fifo_out;
    logic fifo_out_valid;
    // ****************************************
    // helpers
    // ****************************************
    // burst address for step n from start low bits
    function automatic logic [BURST_BITS-1:0] burst_low(
        input logic [BURST_BITS-1:0] start, input logic [BURST_BITS-1:0] n,
        input logic interleave);
        burst_low = interleave ? (start ^ n) : (start + n);
    endfunction
    // merge lanes whose select is active
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
        input logic [LANES-1:0] en);
        lane_merge = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (en[i]) begin
                lane_merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
    endfunction
    // ****************************************
    // decode of the sampled edge
    // ****************************************
    assign go = !clk_qualifier_n;
    assign sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    assign next_cnt = burst_cnt_r + 2'b01;
    assign next_addr = {addr_r[ADDR_W-1:BURST_BITS],
        burst_low(start_addr_r[BURST_BITS-1:0], next_cnt, order_r)};
    // strap is caught after reset release, never under reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            order_taken_r <= 1'b0;
            order_r <= 1'b1;
        end else if (!order_taken_r) begin
            order_taken_r <= 1'b1;
            order_r <= burst_order_strap;
        end
    end
    // address and burst counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= ADDR_RST;
            start_addr_r <= ADDR_RST;
            burst_cnt_r <= 2'b00;
        end else if (go) begin
            if (!advance_or_load && sel) begin
                addr_r <= addr_in;
                start_addr_r <= addr_in;
                burst_cnt_r <= 2'b00;
            end else if (advance_or_load) begin
                addr_r <= next_addr;
                burst_cnt_r <= next_cnt;
            end
        end
    end
    // cycle kind and lane enables for the data phase one edge later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage_r <= CYC_IDLE;
            lane_we_r <= '0;
            was_desel_r <= 1'b1;
        end else if (go) begin
            was_desel_r <= stage_r == CYC_IDLE;
            if (advance_or_load) begin
                // continue burst with last kind; idle stays idle
                lane_we_r <= ~byte_lane_write_sel_n;
            end else if (!sel) begin
                stage_r <= CYC_IDLE;
                lane_we_r <= '0;
            end else if (!write_strobe_n) begin
                stage_r <= CYC_WRITE;
                lane_we_r <= ~byte_lane_write_sel_n;
            end else begin
                stage_r <= CYC_READ;
                lane_we_r <= '0;
            end
        end
    end
    // ****************************************
    // write data path through fifo
    // ****************************************
    assign wr_req_valid = go && stage_r == CYC_WRITE;
    assign wr_req = {addr_r, lane_we_r};
    assign fifo_in = {data_in, wr_req};
    // space flag from a flop so the pin never carries pointer arithmetic;
    // the fifo drains every cycle, so a one-cycle lag cannot overrun it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            write_data_ready_r <= 1'b0;
        end else begin
            write_data_ready_r <= fifo_in_ready;
        end
    end
    assign write_data_ready = write_data_ready_r;
    sram_wdata_fifo #(
        .WIDTH(DATA_W + LANES + ADDR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wfifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(fifo_in),
        .in_valid(wr_req_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );
    // array commit, one word per cycle
    always_ff @(posedge clk_sys) begin
        if (fifo_out_valid) begin
            mem[fifo_out[LANES +: ADDR_W]] <= lane_merge(mem[fifo_out[LANES +: ADDR_W]],
                fifo_out[LANES+ADDR_W +: DATA_W], fifo_out[LANES-1:0]);
        end
    end
    // ****************************************
    // read data and drive control
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_out_r <= DATA_RST;
            data_out_en_r <= 1'b0;
        end else if (go) begin
            data_out_r <= mem[addr_r];
            data_out_en_r <= stage_r == CYC_READ && !was_desel_r && !output_drive_n;
        end
    end
    assign data_out = data_out_r;
    assign data_out_en = data_out_en_r;
    // ****************************************
    // checks
    // ****************************************
    property p_freeze;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_qualifier_n |=> $stable(addr_r) && $stable(stage_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while qualifier high");
    property p_load;
        @(posedge clk_sys) disable iff (!rst_n)
        go && !advance_or_load && sel |=> addr_r == $past(addr_in);
    endproperty
    a_load: assert property (p_load) else $error("address not loaded");
    property p_adv;
        @(posedge clk_sys) disable iff (!rst_n)
        go && advance_or_load |=> addr_r[ADDR_W-1:BURST_BITS] == $past(addr_r[ADDR_W-1:BURST_BITS])
            && burst_cnt_r == $past(burst_cnt_r) + 2'b01;
    endproperty
    a_adv: assert property (p_adv) else $error("burst step wrong");
    property p_desel;
        @(posedge clk_sys) disable iff (!rst_n)
        go && !advance_or_load && !sel |=> stage_r == CYC_IDLE;
    endproperty
    a_desel: assert property (p_desel) else $error("not deselected");
    property p_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        go && !advance_or_load && sel && !write_strobe_n |=> stage_r == CYC_WRITE;
    endproperty
    a_wr: assert property (p_wr) else $error("write not started");
    property p_lanes;
        @(posedge clk_sys) disable iff (!rst_n)
        go && !advance_or_load && sel && !write_strobe_n
            |=> lane_we_r == ~$past(byte_lane_write_sel_n);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane enables wrong");
    property p_hiz;
        @(posedge clk_sys) disable iff (!rst_n)
        go && stage_r != CYC_READ |=> !data_out_en;
    endproperty
    a_hiz: assert property (p_hiz) else $error("driving outside read");
    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_n)
        go && advance_or_load && !order_r |=>
            addr_r[BURST_BITS-1:0] == $past(addr_r[BURST_BITS-1:0]) + 2'b01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("linear wrap wrong");
endmodule
`default_nettype wire

// ---- verification/sram_ctrl_partner.sv ----
// behavioural memory controller that drives the sram control pins
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_partner (
    input wire logic clk_sys,
    output logic clk_qualifier_n,
    output logic chip_select_one_n,
    output logic chip_select_two,
    output logic chip_select_three_n,
    output logic write_strobe_n,
    output logic advance_or_load,
    output logic output_drive_n,
    output logic [sram_port_pkg::ADDR_W-1:0] addr_in,
    output logic [sram_port_pkg::LANES-1:0] byte_lane_write_sel_n,
    output logic [sram_port_pkg::DATA_W-1:0] data_in
);
    import sram_port_pkg::*;
    logic [DATA_W-1:0] pend_d = '0; // write data owed at the next counted edge
    logic pend_v = 1'b0; // a selected write is waiting for its data
    logic oe_hold = 1'b0; // output drive level, set by the bench
    // idle pins: frozen clock, deselected, data scrambled
    initial begin
        {clk_qualifier_n, chip_select_one_n, chip_select_two} = 3'b110;
        {chip_select_three_n, write_strobe_n, advance_or_load} = 3'b010;
        output_drive_n = 1'b0;
        addr_in = '0;
        byte_lane_write_sel_n = 4'hf;
        data_in = 36'h5a5a5a5a5;
    end
    // one bus cycle, launched just after a rising edge, taken at the next
    task automatic cyc(input logic q_n, input logic [2:0] cs, input logic we_n,
        input logic adv, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw_n,
        input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        clk_qualifier_n <= q_n;
        {chip_select_one_n, chip_select_two, chip_select_three_n} <= cs;
        write_strobe_n <= we_n;
        advance_or_load <= adv;
        addr_in <= a;
        byte_lane_write_sel_n <= bw_n;
        output_drive_n <= oe_hold;
        // data moves only at counted edges; idle data is inverted, never stale
        if (!q_n) begin
            data_in <= pend_v ? pend_d : ~data_in;
            pend_v <= !we_n && cs == 3'b010;
            pend_d <= d;
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_sync_burst_sram_ctrl_port.sv ----
// self-checking bench for the burst sram control port
`timescale 1ns/1ps
`default_nettype none
module tb_sync_burst_sram_ctrl_port;
    import sram_port_pkg::*;
    localparam logic [2:0] SEL = 3'b010; // cs1 low, cs2 high, cs3 low
    localparam logic [DATA_W-1:0] D1 = 36'h0a5a5a5a5;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic burst_order_strap = 1'b1;
    logic clk_qualifier_n, chip_select_one_n, chip_select_two, chip_select_three_n;
    logic write_strobe_n, advance_or_load, output_drive_n, data_out_en, write_data_ready;
    logic [ADDR_W-1:0] addr_in;
    logic [LANES-1:0] byte_lane_write_sel_n;
    logic [DATA_W-1:0] data_in, data_out;
    int error_cnt = 0;
    int total_checks = 0;
    int qe = 0; // counted edges since the start of the run; do_reset does not clear it
    logic prev_q_n = 1'b1; // qualifier seen at the coming edge
    logic slot_v [4]; // expected outputs, indexed by counted edge
    logic slot_en [4];
    logic [DATA_W-1:0] slot_d [4];
    always #4 clk_sys = ~clk_sys;
    sync_burst_sram_ctrl_port u_dut (.clk_sys, .rst_n, .clk_qualifier_n, .chip_select_one_n,
        .chip_select_two, .chip_select_three_n, .write_strobe_n, .advance_or_load,
        .burst_order_strap, .output_drive_n, .addr_in, .byte_lane_write_sel_n, .data_in,
        .data_out, .data_out_en, .write_data_ready);
    sram_ctrl_partner u_ctrl (.clk_sys, .clk_qualifier_n, .chip_select_one_n,
        .chip_select_two, .chip_select_three_n, .write_strobe_n, .advance_or_load,
        .output_drive_n, .addr_in, .byte_lane_write_sel_n, .data_in);
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one cycle; outputs of a counted op are judged at the next counted edge
    task automatic step(input logic q_n, input logic [2:0] cs, input logic we_n,
        input logic adv, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw_n,
        input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] exp, input logic en);
        int s;
        u_ctrl.cyc(q_n, cs, we_n, adv, a, bw_n, d);
        #1;
        if (!prev_q_n) begin
            qe++;
            s = qe % 4;
            if (slot_v[s]) begin
                check(36'(data_out_en), 36'(slot_en[s]));
                if (slot_en[s]) check(data_out, slot_d[s]);
            end
        end
        prev_q_n = q_n;
        s = (qe + 2) % 4;
        slot_v[s] = !q_n;
        slot_en[s] = en;
        slot_d[s] = exp;
    endtask
    task automatic idle(input logic q_n);
        step(q_n, 3'b110, 1'b1, 1'b0, '0, 4'hf, '0, '0, 1'b0);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw_n,
        input logic [DATA_W-1:0] d);
        step(1'b0, SEL, 1'b0, 1'b0, a, bw_n, d, '0, 1'b0);
    endtask
    task automatic rd(input logic adv, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] exp, input logic en);
        step(1'b0, SEL, 1'b1, adv, a, 4'hf, '0, exp, en);
    endtask
    task automatic do_reset(input logic strap);
        idle(1'b1);
        burst_order_strap <= strap;
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (slot_v[i]) slot_v[i] = 1'b0;
        @(posedge clk_sys);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_lanes();
        idle(1'b0);
        wr(19'h00010, 4'h0, 36'h123456789);
        wr(19'h00011, 4'h0, 36'hfedcba987);
        wr(19'h00010, 4'b1010, '0);
        check(36'(write_data_ready), 36'h000000001);
        rd(1'b0, 19'h00011, 36'hfedcba987, 1'b1);
        rd(1'b0, 19'h00010, 36'h123456789 & ~36'h007fc01ff, 1'b1);
        idle(1'b0);
        rd(1'b0, 19'h00011, '0, 1'b0);
        rd(1'b0, 19'h00011, 36'hfedcba987, 1'b1);
        rd(1'b0, 19'h00011, '0, 1'b0);
        // drive level counts at the edge that updates the outputs, one op later
        u_ctrl.oe_hold = 1'b1;
        idle(1'b0);
        idle(1'b0);
        u_ctrl.oe_hold = 1'b0;
        $display("test lanes done");
    endtask
    task automatic t_freeze_cs();
        wr(19'h00020, 4'h0, D1);
        step(1'b1, SEL, 1'b0, 1'b0, 19'h00020, 4'h0, 36'h123123123, '0, 1'b0);
        // other address first: no forwarding, the commit lands one edge late
        rd(1'b0, 19'h00011, 36'hfedcba987, 1'b1);
        rd(1'b0, 19'h00020, D1, 1'b1);
        idle(1'b1);
        idle(1'b1);
        for (int c = 0; c < 8; c++) begin
            if (c != 2) step(1'b0, 3'(c), 1'b0, 1'b0, 19'h00020, 4'h0, '1, '0, 1'b0);
        end
        rd(1'b0, 19'h00020, '0, 1'b0);
        rd(1'b0, 19'h00020, D1, 1'b1);
        idle(1'b0);
        $display("test freeze and select done");
    endtask
    task automatic t_burst(input logic strap);
        do_reset(strap);
        idle(1'b0);
        for (int i = 0; i < 4; i++) wr(19'h2a5f0 + 19'(i), 4'h0, 36'h0c3c3c300 | 36'(i));
        rd(1'b0, 19'h2a5f1, 36'h0c3c3c301, 1'b1);
        step(1'b1, SEL, 1'b1, 1'b1, '0, 4'hf, '0, '0, 1'b0);
        for (int i = 1; i < 4; i++) begin
            rd(1'b1, 19'h05a0e, 36'h0c3c3c300 | 36'(strap ? (1 ^ i) : ((1 + i) % 4)), 1'b1);
        end
        idle(1'b0);
        $display("test burst order %0d done", strap);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        do_reset(1'b1);
        t_lanes();
        t_freeze_cs();
        t_burst(1'b0);
        t_burst(1'b1);
        repeat (3) idle(1'b0);
        complete_run();
    end
    // whole run is under a hundred cycles; this span means a hang
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
